// ### arsq_pkg.sv
// constants and types of the automatic restart sequencer
package arsq_pkg;
  // ********************************************
  // register offsets and fields
  // ********************************************
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] DELAY_OFS = 4'h4;
  localparam logic [3:0] WATCH_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hc;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ATT_LSB = 8;
  localparam int CTRL_CLR_BIT = 31;
  localparam int STAT_ATT_LSB = 8;
  localparam int STAT_FAIL_BIT = 16;
  localparam int STAT_PWR_BIT = 17;
  // ********************************************
  // reset values
  // ********************************************
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [7:0] ATT_RST = 8'h03;
  localparam logic [15:0] DELAY_RST = 16'h0bb8;
  localparam logic [15:0] WATCH_RST = 16'h0000;
  // ********************************************
  // timing
  // ********************************************
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int SUCCESS_S = 1;
  localparam int SUCCESS_MS = SUCCESS_S * 1000 / TICK_MS;
  // ********************************************
  // modes, responses and states
  // ********************************************
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_ACK = 4'h1;
  localparam logic [3:0] MODE_LINE = 4'h4;
  localparam logic [3:0] MODE_ANY = 4'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ACK = 3'h1,
    ST_POWER = 3'h3,
    ST_CONFIRM = 3'h2,
    ST_FAILED = 3'h6
  } arsq_state_t;
endpackage

// ### arsq_top.sv
// automatic restart sequencer with axi4-lite register slave
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module arsq_top #(
  parameter int TICK_CYCLES = arsq_pkg::TICK_CYCLES,
  parameter int ATT_W = 8
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  // axi4-lite write channels
  input wire logic [3:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // axi4-lite read channels
  input wire logic [3:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // drive status
  input wire logic FAULT_PRESENT_I,
  input wire logic ACK_POSSIBLE_I,
  input wire logic UNDERVOLT_FAULT_I,
  input wire logic INFEED_LINE_FAULT_I,
  input wire logic [1:0] INFEED_FAULT_INPUTS_I,
  input wire logic CU_SUPPLY_LOST_I,
  input wire logic SUPPLY_READY_I,
  input wire logic MAGNETIZATION_DONE_I,
  input wire logic RUN_COMMAND_I,
  // drive commands
  output logic FAULT_ACK_O,
  output logic POWER_UP_CMD_O,
  output logic RESTART_FAILED_FAULT_O,
  output logic BUSY_O
);
  // ********************************************
  // state
  // ********************************************
  typedef struct packed {
    arsq_pkg::arsq_state_t state;
    logic [15:0] pre;
    logic [15:0] ack_ms;
    logic [15:0] watch_ms;
    logic watch_on;
    logic [15:0] conf_ms;
    logic [ATT_W-1:0] att;
    logic fail;
    logic ack;
    logic pwr;
    logic [3:0] mode;
    logic [ATT_W-1:0] att_cfg;
    logic [15:0] delay;
    logic [15:0] watch;
    logic aw_got;
    logic w_got;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } arsq_st_t;

  localparam arsq_st_t RST = '{
    state: arsq_pkg::ST_IDLE,
    att: ATT_W'(arsq_pkg::ATT_RST),
    mode: arsq_pkg::MODE_RST,
    att_cfg: ATT_W'(arsq_pkg::ATT_RST),
    delay: arsq_pkg::DELAY_RST,
    watch: arsq_pkg::WATCH_RST,
    default: '0
  };

  arsq_st_t r_ff;
  arsq_st_t nxt_r;
  logic [3:0] m;
  logic tick;
  logic fire;
  logic trig;
  logic wexp;
  logic [15:0] half;

  // merge written bytes into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ********************************************
  // decoded conditions
  // ********************************************
  // unknown mode codes fall back to off
  assign m = (r_ff.mode == arsq_pkg::MODE_ACK || r_ff.mode == arsq_pkg::MODE_LINE ||
              r_ff.mode == arsq_pkg::MODE_ANY) ? r_ff.mode : arsq_pkg::MODE_OFF;
  // common millisecond tick
  assign tick = (r_ff.pre == 16'(TICK_CYCLES - 1));
  assign fire = (r_ff.state == arsq_pkg::ST_ACK) && (r_ff.ack_ms == 16'h0000);
  // half delay time, never below one tick
  assign half = (r_ff.delay[15:1] == 15'h0000) ? 16'h0001 : {1'b0, r_ff.delay[15:1]};
  // trigger events per mode
  always_comb begin
    unique case (m)
      arsq_pkg::MODE_ACK: trig = FAULT_PRESENT_I;
      arsq_pkg::MODE_LINE: trig = UNDERVOLT_FAULT_I | INFEED_FAULT_INPUTS_I[1] |
                                  INFEED_LINE_FAULT_I | CU_SUPPLY_LOST_I;
      arsq_pkg::MODE_ANY: trig = FAULT_PRESENT_I | INFEED_FAULT_INPUTS_I[0];
      default: trig = 1'b0;
    endcase
  end
  // watch expiry, off when the limit is zero; no guard against short limits
  assign wexp = r_ff.watch_on && (r_ff.watch != 16'h0000) && tick &&
                (r_ff.watch_ms + 16'h0001 >= r_ff.watch);

  // ********************************************
  // next state
  // ********************************************
  always_comb begin
    logic clr;
    logic set;
    logic [31:0] wv;
    clr = 1'b0;
    set = 1'b0;
    wv = 32'h0000_0000;
    nxt_r = r_ff;
    nxt_r.ack = 1'b0;
    nxt_r.pre = tick ? 16'h0000 : r_ff.pre + 16'h0001;
    // axi write: address and data in either order
    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      nxt_r.aw_got = 1'b1;
      nxt_r.awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      nxt_r.w_got = 1'b1;
      nxt_r.wdata = S_AXI_WDATA_I;
      nxt_r.wstrb = S_AXI_WSTRB_I;
    end
    if (r_ff.aw_got && r_ff.w_got) begin
      nxt_r.aw_got = 1'b0;
      nxt_r.w_got = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp = arsq_pkg::RESP_OKAY;
      unique case (r_ff.awaddr)
        arsq_pkg::CTRL_OFS: begin
          wv = merge(32'({r_ff.att_cfg, 4'h0, r_ff.mode}), r_ff.wdata, r_ff.wstrb);
          nxt_r.mode = wv[arsq_pkg::CTRL_MODE_LSB +: 4];
          nxt_r.att_cfg = wv[arsq_pkg::CTRL_ATT_LSB +: ATT_W];
          clr = r_ff.wstrb[3] && r_ff.wdata[arsq_pkg::CTRL_CLR_BIT];
        end
        arsq_pkg::DELAY_OFS: begin
          wv = merge({16'h0000, r_ff.delay}, r_ff.wdata, r_ff.wstrb);
          nxt_r.delay = wv[15:0];
        end
        arsq_pkg::WATCH_OFS: begin
          wv = merge({16'h0000, r_ff.watch}, r_ff.wdata, r_ff.wstrb);
          nxt_r.watch = wv[15:0];
        end
        arsq_pkg::STAT_OFS: nxt_r.bresp = arsq_pkg::RESP_OKAY;
        default: nxt_r.bresp = arsq_pkg::RESP_SLVERR;
      endcase
    end
    if (r_ff.bvalid && S_AXI_BREADY_I) begin
      nxt_r.bvalid = 1'b0;
    end
    // axi read
    if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rresp = arsq_pkg::RESP_OKAY;
      nxt_r.rdata = 32'h0000_0000;
      unique case (S_AXI_ARADDR_I)
        arsq_pkg::CTRL_OFS: begin
          nxt_r.rdata[arsq_pkg::CTRL_MODE_LSB +: 4] = r_ff.mode;
          nxt_r.rdata[arsq_pkg::CTRL_ATT_LSB +: ATT_W] = r_ff.att_cfg;
        end
        arsq_pkg::DELAY_OFS: nxt_r.rdata[15:0] = r_ff.delay;
        arsq_pkg::WATCH_OFS: nxt_r.rdata[15:0] = r_ff.watch;
        arsq_pkg::STAT_OFS: begin
          nxt_r.rdata[2:0] = r_ff.state;
          nxt_r.rdata[arsq_pkg::STAT_ATT_LSB +: ATT_W] = r_ff.att;
          nxt_r.rdata[arsq_pkg::STAT_FAIL_BIT] = r_ff.fail;
          nxt_r.rdata[arsq_pkg::STAT_PWR_BIT] = r_ff.pwr;
        end
        default: nxt_r.rresp = arsq_pkg::RESP_SLVERR;
      endcase
    end else if (r_ff.rvalid && S_AXI_RREADY_I) begin
      nxt_r.rvalid = 1'b0;
    end
    // watch timer counts while an attempt is open
    if (r_ff.watch_on && tick) begin
      nxt_r.watch_ms = r_ff.watch_ms + 16'h0001;
    end
    // sequencer
    unique case (r_ff.state)
      arsq_pkg::ST_IDLE: begin
        nxt_r.att = r_ff.att_cfg;
        nxt_r.watch_on = 1'b0;
        // the fault still shows while our own acknowledge pulse stands
        if (trig && !r_ff.ack) begin
          nxt_r.state = arsq_pkg::ST_ACK;
          nxt_r.ack_ms = 16'h0000;
          nxt_r.watch_ms = 16'h0000;
          nxt_r.watch_on = 1'b1;
        end
      end
      arsq_pkg::ST_ACK: begin
        if (fire) begin
          nxt_r.ack = 1'b1;
          nxt_r.ack_ms = half;
          if (!ACK_POSSIBLE_I) begin
            nxt_r.watch_ms = 16'h0000;
          end else if (m == arsq_pkg::MODE_ACK) begin
            nxt_r.state = arsq_pkg::ST_IDLE;
          end else if (m == arsq_pkg::MODE_ANY && r_ff.att == '0) begin
            set = 1'b1;
          end else begin
            if (m == arsq_pkg::MODE_ANY) begin
              nxt_r.att = r_ff.att - ATT_W'(1);
            end
            nxt_r.state = arsq_pkg::ST_POWER;
          end
        end else if (tick) begin
          nxt_r.ack_ms = r_ff.ack_ms - 16'h0001;
        end
      end
      arsq_pkg::ST_POWER, arsq_pkg::ST_CONFIRM: begin
        // a fault seen during our acknowledge pulse is the one just cleared
        if (FAULT_PRESENT_I && !r_ff.ack) begin
          nxt_r.state = arsq_pkg::ST_ACK;
          nxt_r.ack_ms = 16'h0000;
        end else if (r_ff.state == arsq_pkg::ST_POWER) begin
          if (MAGNETIZATION_DONE_I) begin
            nxt_r.state = arsq_pkg::ST_CONFIRM;
            nxt_r.conf_ms = 16'h0000;
            nxt_r.watch_on = 1'b0;
          end
        end else if (tick) begin
          nxt_r.conf_ms = r_ff.conf_ms + 16'h0001;
          if (r_ff.conf_ms == 16'(arsq_pkg::SUCCESS_MS - 1)) begin
            nxt_r.state = arsq_pkg::ST_IDLE;
            nxt_r.att = r_ff.att_cfg;
          end
        end
      end
      arsq_pkg::ST_FAILED: begin
        nxt_r.watch_on = 1'b0;
        if (clr) begin
          nxt_r.state = arsq_pkg::ST_IDLE;
        end
      end
      default: nxt_r.state = arsq_pkg::ST_IDLE;
    endcase
    // watch expiry before magnetization
    if (wexp && r_ff.state != arsq_pkg::ST_FAILED && !MAGNETIZATION_DONE_I) begin
      set = 1'b1;
    end
    if (set) begin
      nxt_r.state = arsq_pkg::ST_FAILED;
      nxt_r.watch_on = 1'b0;
    end
    // inactive modes return to idle and drop the acknowledge, but a failed state is kept
    if (m == arsq_pkg::MODE_OFF && r_ff.state != arsq_pkg::ST_FAILED) begin
      nxt_r.state = arsq_pkg::ST_IDLE;
      nxt_r.ack = 1'b0;
      set = 1'b0;
    end else if (m == arsq_pkg::MODE_ACK && (r_ff.state == arsq_pkg::ST_POWER ||
                                             r_ff.state == arsq_pkg::ST_CONFIRM)) begin
      nxt_r.state = arsq_pkg::ST_IDLE;
    end
    // fault flag: a set wins over a clear in the same cycle
    nxt_r.fail = set | (r_ff.fail & ~clr);
    nxt_r.pwr = (nxt_r.state == arsq_pkg::ST_POWER) && SUPPLY_READY_I;
  end

  // ********************************************
  // state register
  // ********************************************
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      r_ff <= RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // outputs
  assign S_AXI_AWREADY_O = !r_ff.aw_got && !r_ff.bvalid;
  assign S_AXI_WREADY_O = !r_ff.w_got && !r_ff.bvalid;
  assign S_AXI_BVALID_O = r_ff.bvalid;
  assign S_AXI_BRESP_O = r_ff.bresp;
  assign S_AXI_ARREADY_O = !r_ff.rvalid;
  assign S_AXI_RVALID_O = r_ff.rvalid;
  assign S_AXI_RDATA_O = r_ff.rdata;
  assign S_AXI_RRESP_O = r_ff.rresp;
  assign FAULT_ACK_O = r_ff.ack;
  assign POWER_UP_CMD_O = r_ff.pwr;
  assign RESTART_FAILED_FAULT_O = r_ff.fail;
  assign BUSY_O = (r_ff.state != arsq_pkg::ST_IDLE);

  // ********************************************
  // assertions
  // ********************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);

  a_mode0_no_ack: assert property ((m == arsq_pkg::MODE_OFF) |=> !FAULT_ACK_O)
    else $error("acknowledge issued while inactive");
  a_mode1_no_power: assert property ((m == arsq_pkg::MODE_ACK) |=> !POWER_UP_CMD_O)
    else $error("power up commanded in acknowledge only mode");
  a_immediate_ack: assert property ((r_ff.state == arsq_pkg::ST_IDLE && trig && !r_ff.ack &&
    m != arsq_pkg::MODE_OFF && !wexp) |=> ##1 FAULT_ACK_O)
    else $error("first acknowledge not immediate");
  a_count_exhaust: assert property ((fire && ACK_POSSIBLE_I && m == arsq_pkg::MODE_ANY &&
    r_ff.att == '0) |=> RESTART_FAILED_FAULT_O)
    else $error("exhausted attempts did not fault");
  a_count_dec: assert property ((fire && ACK_POSSIBLE_I && m == arsq_pkg::MODE_ANY &&
    r_ff.att != '0) |=> (r_ff.att == $past(r_ff.att) - ATT_W'(1)))
    else $error("attempt counter not decremented");
  a_mode1_no_fail: assert property ((m == arsq_pkg::MODE_ACK && fire && !ACK_POSSIBLE_I &&
    !wexp && !r_ff.fail) |=> !RESTART_FAILED_FAULT_O)
    else $error("failed acknowledge raised fault in mode 1");
  a_watch_off: assert property ((r_ff.watch == 16'h0000 && m != arsq_pkg::MODE_ANY &&
    !r_ff.fail) |=> !RESTART_FAILED_FAULT_O)
    else $error("fault raised with supervision off");
  a_success_reload: assert property ((r_ff.state == arsq_pkg::ST_CONFIRM && tick &&
    !FAULT_PRESENT_I && m == arsq_pkg::MODE_ANY && !wexp &&
    r_ff.conf_ms == 16'(arsq_pkg::SUCCESS_MS - 1)) |=> (r_ff.att == r_ff.att_cfg))
    else $error("counter not reloaded after success");
  a_power_supply: assert property (POWER_UP_CMD_O |-> $past(SUPPLY_READY_I))
    else $error("power up without supply");
  c_fail_raised: cover property ($rose(RESTART_FAILED_FAULT_O));
  c_success: cover property (r_ff.state == arsq_pkg::ST_CONFIRM ##1 r_ff.state == arsq_pkg::ST_IDLE);
  c_mode1_ack: cover property (m == arsq_pkg::MODE_ACK && FAULT_ACK_O);
endmodule

`default_nettype wire

// ### arsq_fix_note_unused.sv
// spare source file, holds no logic

// ### arsq_drive_model.sv
// drive-side fault, supply and magnetization model for the sequencer bench
`timescale 1ns/1ps
`default_nettype none
module arsq_drive_model #(
  parameter int MAG_CYC = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // bench controls
  input wire logic inject_i,
  input wire logic ack_ok_i,
  input wire logic supply_ok_i,
  // sequencer commands
  input wire logic fault_ack_i,
  input wire logic power_up_i,
  // drive status
  output logic fault_present_o,
  output logic ack_possible_o,
  output logic supply_ready_o,
  output logic mag_done_o
);
  logic fault_ff;
  logic [7:0] mag_ff;
  // fault latch, cleared only by an acknowledge that can succeed
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_ff <= 1'b0;
      mag_ff <= 8'h00;
    end else if (inject_i) begin
      fault_ff <= 1'b1;
      mag_ff <= 8'h00;
    end else begin
      if (fault_ack_i && ack_ok_i) fault_ff <= 1'b0;
      if (power_up_i && mag_ff != 8'(MAG_CYC)) mag_ff <= mag_ff + 8'h01;
    end
  end
  // status levels, magnetization held once reached until the next injected fault
  assign fault_present_o = fault_ff;
  assign ack_possible_o = ack_ok_i;
  assign supply_ready_o = supply_ok_i;
  assign mag_done_o = (mag_ff == 8'(MAG_CYC));
endmodule
`default_nettype wire

// ### test_auto_restart_sequencer.sv
// self-checking bench of the automatic restart sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_auto_restart_sequencer;
  typedef struct packed {logic [3:0] mode; logic [2:0] kind; logic ack; logic pwr;} arsq_row_t;
  logic mclk, reset_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, uv, line, cu, run, inject, ack_ok, supply_ok, fault_pres, ack_pos;
  logic sup_rdy, mag_done, fault_ack, pwr, fail, busy;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] bresp, rresp, rr, lb, infeed;
  int n_errors, check_count, cyc, n, na, np, fs;
  int t [3];
  // kinds: 0 fault, 1 undervoltage, 2 infeed bit1, 3 infeed bit0, 4 cu supply, 5 line fault
  arsq_row_t rows [10] = '{'{4'h0, 3'h0, 1'b0, 1'b0}, '{4'h5, 3'h0, 1'b0, 1'b0},
    '{4'h1, 3'h0, 1'b1, 1'b0}, '{4'h4, 3'h0, 1'b0, 1'b0}, '{4'h4, 3'h1, 1'b1, 1'b1},
    '{4'h4, 3'h2, 1'b1, 1'b1}, '{4'h4, 3'h5, 1'b1, 1'b1}, '{4'h4, 3'h4, 1'b1, 1'b1},
    '{4'h6, 3'h0, 1'b1, 1'b1}, '{4'h6, 3'h3, 1'b1, 1'b1}};
  logic [3:0] offs [3] = '{arsq_pkg::CTRL_OFS, arsq_pkg::DELAY_OFS, arsq_pkg::WATCH_OFS};
  logic [31:0] rst_val [3] = '{{16'h0, arsq_pkg::ATT_RST, 4'h0, arsq_pkg::MODE_RST},
    {16'h0, arsq_pkg::DELAY_RST}, {16'h0, arsq_pkg::WATCH_RST}};

  // design with a four-cycle millisecond tick
  arsq_top #(.TICK_CYCLES(4), .ATT_W(8)) u_dut (.MCLK_I(mclk), .RESET_N_I(reset_n),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .FAULT_PRESENT_I(fault_pres),
    .ACK_POSSIBLE_I(ack_pos), .UNDERVOLT_FAULT_I(uv), .INFEED_LINE_FAULT_I(line),
    .INFEED_FAULT_INPUTS_I(infeed), .CU_SUPPLY_LOST_I(cu), .SUPPLY_READY_I(sup_rdy),
    .MAGNETIZATION_DONE_I(mag_done), .RUN_COMMAND_I(run), .FAULT_ACK_O(fault_ack),
    .POWER_UP_CMD_O(pwr), .RESTART_FAILED_FAULT_O(fail), .BUSY_O(busy));

  // drive status model on the far side
  arsq_drive_model #(.MAG_CYC(20)) u_drive (.clk_i(mclk), .rst_n_i(reset_n),
    .inject_i(inject), .ack_ok_i(ack_ok), .supply_ok_i(supply_ok), .fault_ack_i(fault_ack),
    .power_up_i(pwr), .fault_present_o(fault_pres), .ack_possible_o(ack_pos),
    .supply_ready_o(sup_rdy), .mag_done_o(mag_done));

  // 40 mhz clock and hang guard
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 14000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // reset held for five clocks
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
  endtask

  // axi4-lite write, each half released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    lb = bresp;
  endtask

  // axi4-lite read, data taken at the rvalid edge
  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    rr = rresp;
  endtask

  function automatic logic [31:0] ctrl(input logic [3:0] m, input logic [7:0] c);
    ctrl = {16'h0, c, 4'h0, m};
  endfunction

  function automatic bit ev(input int k);
    case (k)
      0: ev = (fault_ack === 1'b1);
      1: ev = (busy === 1'b0);
      2: ev = (fail === 1'b1);
      default: ev = (mag_done === 1'b1);
    endcase
  endfunction

  // bounded wait for an event, count of edges returned
  task automatic wait_ev(input int k, input int lim);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!ev(k) && n < lim);
  endtask

  // single fault; repeats spaced by reset, a whole attempt or a few cycles after an acknowledge
  task automatic pulse_fault();
    inject <= 1'b1;
    @(posedge mclk);
    inject <= 1'b0;
  endtask

  task automatic trig(input logic [2:0] k);
    inject <= (k == 3'h0) || (k == 3'h1) || (k == 3'h5);
    uv <= (k == 3'h1);
    infeed <= {k == 3'h2, k == 3'h3};
    cu <= (k == 3'h4);
    line <= (k == 3'h5);
  endtask

  // setup with given mode and watch limit, count 1, delay 8 ms
  task automatic setup(input logic [3:0] m, input logic [15:0] w);
    do_reset();
    wr(arsq_pkg::DELAY_OFS, 32'h8);
    wr(arsq_pkg::WATCH_OFS, {16'h0, w});
    wr(arsq_pkg::CTRL_OFS, ctrl(m, 8'h01));
  endtask

  initial begin
    mclk = 0; reset_n = 0; awvalid = 0; wvalid = 0; arvalid = 0; bready = 1; rready = 1;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hf; uv = 0; line = 0; cu = 0; run = 1;
    infeed = 0; inject = 0; ack_ok = 1; supply_ok = 1;
    // register reset values and bus responses
    do_reset();
    for (int k = 0; k < 3; k++) begin
      rd(offs[k]);
      `CHK("reg", rst_val[k], rv);
    end
    rd(4'h2);
    `CHK("rresp", arsq_pkg::RESP_SLVERR, rr);
    wr(arsq_pkg::STAT_OFS, 32'hffffffff);
    `CHK("bresp", arsq_pkg::RESP_OKAY, lb);
    // mode and trigger table
    for (int i = 0; i < 10; i++) begin
      do_reset();
      wr(arsq_pkg::DELAY_OFS, 32'h8);
      wr(arsq_pkg::CTRL_OFS, ctrl(rows[i].mode, 8'h03));
      trig(rows[i].kind);
      na = 0;
      np = 0;
      for (int c = 1; c <= 60; c++) begin
        @(posedge mclk);
        if (c == 1) inject <= 1'b0;
        if (c == 4) trig(3'h7);
        na += (fault_ack === 1'b1);
        np += (pwr === 1'b1);
      end
      `CHK("ack", rows[i].ack, na != 0);
      `CHK("power", rows[i].pwr, np != 0);
    end
    // successful attempt, counter decrement and reload
    setup(arsq_pkg::MODE_ANY, 16'h0);
    pulse_fault();
    wait_ev(0, 100);
    `CHK("first ack", 1'b1, n <= 4);
    rd(arsq_pkg::STAT_OFS);
    `CHK("count", 8'h00, rv[15:8]);
    wait_ev(3, 200);
    repeat (3900) @(posedge mclk);
    `CHK("busy", 1'b1, busy);
    wait_ev(1, 300);
    rd(arsq_pkg::STAT_OFS);
    `CHK("reload", 8'h01, rv[15:8]);
    // extra fault within an attempt exhausts the count
    pulse_fault();
    wait_ev(0, 100);
    repeat (4) @(posedge mclk);
    pulse_fault();
    wait_ev(2, 200);
    `CHK("fail", 1'b1, fail);
    wr(arsq_pkg::CTRL_OFS, ctrl(arsq_pkg::MODE_ANY, 8'h01) | 32'h80000000);
    repeat (2) @(posedge mclk);
    `CHK("cleared", 2'b00, {fail, busy});
    // retry spacing with watch off in mode 6, no fault in modes 6 and 1
    for (int j = 0; j < 2; j++) begin
      setup(j ? arsq_pkg::MODE_ACK : arsq_pkg::MODE_ANY, 16'h0);
      ack_ok <= 1'b0;
      pulse_fault();
      na = 0;
      fs = 0;
      t = '{0, 0, 0};
      for (int c = 1; c <= 200; c++) begin
        @(posedge mclk);
        if (fault_ack === 1'b1 && na < 3) t[na++] = c;
        fs += (fail === 1'b1);
      end
      if (j == 0) `CHK("retry gap", 16, t[2] - t[1]);
      `CHK("no fail", 0, fs);
      ack_ok <= 1'b1;
    end
    // watch expiry, later when failed acks restart it
    for (int j = 0; j < 2; j++) begin
      setup(arsq_pkg::MODE_ANY, 16'h14);
      ack_ok <= (j == 0);
      supply_ok <= 1'b0;
      pulse_fault();
      n = 0;
      do begin
        @(posedge mclk);
        n++;
        if (n == 40) ack_ok <= 1'b1;
      end while (fail !== 1'b1 && n < 400);
      `CHK("watch", 1'b1, j ? n > 100 && n < 400 : n >= 72 && n <= 90);
      supply_ok <= 1'b1;
    end
    finish_test();
  end
endmodule
`default_nettype wire
